//--- src/occ_channel.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "occ_regs.svh"
module occ_channel
    import occ_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] second_timer_count,
    input wire logic second_timer_rollover,
    input wire logic [15:0] third_timer_count,
    input wire logic third_timer_rollover,
    input wire logic compare_fault_input,
    input wire logic cpu_idle,
    output logic compare_output_pin,
    output logic compare_output_enable,
    output logic compare_event
);

    function automatic logic is_pwm(input occ_mode_t m);
        is_pwm = (m == OCC_MODE_PWM) || (m == OCC_MODE_PWM_FAULT);
    endfunction

    function automatic logic nonzero(input logic [15:0] v);
        nonzero = (v != `OCC_ZERO16);
    endfunction

    // control and data registers
    logic idle_stop_r;
    logic tsel_r;
    occ_mode_t mode_r;
    logic fault_r;
    logic fault_nxt;
    logic [15:0] pri_r;
    logic [15:0] pri_nxt;
    logic [15:0] sec_r;
    logic [15:0] evcnt_r;
    logic [15:0] evcnt_nxt;
    logic init_r;

    // output stage and sequencing
    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic evt_r;
    logic evt_nxt;
    occ_seq_t seq_r;
    occ_seq_t seq_nxt;
    logic eq_pri_prev_r;
    logic eq_sec_prev_r;
    logic flt_prev_r;

    // bus answer
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    // selected time base
    logic [15:0] tb_count;
    logic tb_rollover;
    logic eq_pri;
    logic eq_sec;
    logic flt_sync;

    occ_match u_match (
        .tsel(tsel_r),
        .second_timer_count(second_timer_count),
        .second_timer_rollover(second_timer_rollover),
        .third_timer_count(third_timer_count),
        .third_timer_rollover(third_timer_rollover),
        .cmp_pri(pri_r),
        .cmp_sec(sec_r),
        .count(tb_count),
        .rollover(tb_rollover),
        .eq_pri(eq_pri),
        .eq_sec(eq_sec)
    );

    // fault pin idles high; reset to high so release gives no false edge
    occ_sync #(
        .INIT(1'b1)
    ) u_flt_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(compare_fault_input),
        .sync_out(flt_sync)
    );

    // bus decode
    wire setup_ph = psel & ~penable;
    wire access_done = psel & penable & pready_r;
    wire wr_done = access_done & pwrite;
    wire sel_ctrl = (paddr == `OCC_CTRL_OFS);
    wire sel_pri = (paddr == `OCC_PRI_OFS);
    wire sel_sec = (paddr == `OCC_SEC_OFS);
    wire sel_stat = (paddr == `OCC_STAT_OFS);
    wire sel_time = (paddr == `OCC_TIME_OFS);
    wire sel_evcnt = (paddr == `OCC_EVCNT_OFS);
    wire addr_hit = sel_ctrl | sel_pri | sel_sec | sel_stat | sel_time
                    | sel_evcnt;
    wire wr_ctrl = wr_done & sel_ctrl;
    wire wr_pri = wr_done & sel_pri;
    wire wr_sec = wr_done & sel_sec;
    wire wr_evcnt = wr_done & sel_evcnt;

    // channel activity; halting gates matching, period reloads and fault edges, so the bus, the
    // status word and the init of a newly written mode still work
    // while the cpu idles, and software can reconfigure a halted channel
    wire halted = idle_stop_r & cpu_idle;
    wire run = (mode_r != OCC_MODE_OFF) & ~halted;

    // only bits 13, 4, 3 and 2:0 exist; the rest stay zero
    wire [15:0] ctrl_word = {2'b00, idle_stop_r, 8'h00, fault_r, tsel_r,
                             mode_r};
    wire [15:0] stat_word = {10'h000, seq_r, (seq_r == OCC_SEQ_DONE),
                             run, oe_r, pin_r};
    wire [31:0] rd_word = sel_ctrl ? {`OCC_ZERO16, ctrl_word} :
                          sel_pri ? {`OCC_ZERO16, pri_r} :
                          sel_sec ? {`OCC_ZERO16, sec_r} :
                          sel_stat ? {`OCC_ZERO16, stat_word} :
                          sel_time ? {`OCC_ZERO16, tb_count} :
                          sel_evcnt ? {`OCC_ZERO16, evcnt_r} :
                          32'h0000_0000;

    // a match counts once, on the cycle the count arrives at the value
    wire hit_pri = eq_pri & ~eq_pri_prev_r;
    wire hit_sec = eq_sec & ~eq_sec_prev_r;
    wire flt_fall = flt_prev_r & ~flt_sync;
    wire pwm_reload = run & is_pwm(mode_r) & tb_rollover;
    wire [2:0] new_mode = pwdata[`OCC_MODE_MSB:`OCC_MODE_LSB];

    // bus answer: one wait-free access phase, data captured at setup
    // capturing at setup keeps prdata still for the whole access cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
            pslverr_r <= setup_ph & ~addr_hit;
            if (setup_ph) begin
                prdata_r <= rd_word;
            end
        end
    end

    // control register; a write re-enters the mode with its initial pin
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idle_stop_r <= 1'b0;
            tsel_r <= 1'b0;
            mode_r <= OCC_MODE_OFF;
            init_r <= 1'b0;
        end else begin
            init_r <= wr_ctrl;
            if (wr_ctrl) begin
                idle_stop_r <= pwdata[`OCC_IDLE_BIT];
                tsel_r <= pwdata[`OCC_TSEL_BIT];
                mode_r <= occ_mode_t'(new_mode);
            end
        end
    end

    // duty reload at the period boundary; a bus write wins the same cycle
    always_comb begin
        pri_nxt = pri_r;
        if (wr_pri) begin
            pri_nxt = pwdata[15:0];
        end else if (pwm_reload) begin
            pri_nxt = sec_r;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pri_r <= `OCC_CMP_RST;
            sec_r <= `OCC_CMP_RST;
        end else begin
            pri_r <= pri_nxt;
            if (wr_sec) begin
                sec_r <= pwdata[15:0];
            end
        end
    end

    // pin sequencing per mode
    always_comb begin
        pin_nxt = pin_r;
        seq_nxt = seq_r;
        evt_nxt = 1'b0;
        if (init_r) begin
            seq_nxt = OCC_SEQ_ARMED;
            case (mode_r)
                OCC_MODE_OFF: pin_nxt = pin_r;
                OCC_MODE_RISE_SHOT: pin_nxt = 1'b0;
                OCC_MODE_FALL_SHOT: pin_nxt = 1'b1;
                OCC_MODE_TOGGLE: pin_nxt = pin_r;
                OCC_MODE_DELAY_SHOT: pin_nxt = 1'b0;
                OCC_MODE_PULSES: pin_nxt = 1'b0;
                OCC_MODE_PWM: pin_nxt = nonzero(pri_r);
                OCC_MODE_PWM_FAULT: pin_nxt = nonzero(pri_r);
                default: pin_nxt = 1'b0;
            endcase
        end else if (run) begin
            case (mode_r)
                OCC_MODE_RISE_SHOT: begin
                    if (hit_pri && seq_r == OCC_SEQ_ARMED) begin
                        pin_nxt = 1'b1;
                        evt_nxt = 1'b1;
                        seq_nxt = OCC_SEQ_DONE;
                    end
                end
                OCC_MODE_FALL_SHOT: begin
                    if (hit_pri && seq_r == OCC_SEQ_ARMED) begin
                        pin_nxt = 1'b0;
                        evt_nxt = 1'b1;
                        seq_nxt = OCC_SEQ_DONE;
                    end
                end
                OCC_MODE_TOGGLE: begin
                    if (hit_pri) begin
                        pin_nxt = ~pin_r;
                        evt_nxt = 1'b1;
                    end
                end
                OCC_MODE_DELAY_SHOT, OCC_MODE_PULSES: begin
                    // primary match starts the pulse, secondary ends it
                    if (seq_r == OCC_SEQ_ARMED && hit_pri) begin
                        pin_nxt = 1'b1;
                        seq_nxt = OCC_SEQ_ACTIVE;
                    end else if (seq_r == OCC_SEQ_ACTIVE && hit_sec) begin
                        pin_nxt = 1'b0;
                        evt_nxt = 1'b1;
                        seq_nxt = (mode_r == OCC_MODE_PULSES)
                                  ? OCC_SEQ_ARMED
                                  : OCC_SEQ_DONE;
                    end
                end
                OCC_MODE_PWM, OCC_MODE_PWM_FAULT: begin
                    // zero duty never raises the pin at the boundary
                    if (tb_rollover) begin
                        pin_nxt = nonzero(sec_r);
                    end else if (hit_pri) begin
                        pin_nxt = 1'b0;
                    end
                    // the fault force comes last so it beats the restart
                    if (mode_r == OCC_MODE_PWM_FAULT) begin
                        if (flt_fall) begin
                            evt_nxt = 1'b1;
                        end
                        if (flt_fall || fault_r) begin
                            pin_nxt = 1'b0;
                        end
                    end
                end
                default: begin
                    pin_nxt = pin_r;
                end
            endcase
        end
    end

    // fault latch: set by a fault edge in the running fault pwm mode, cleared only by a
    // control write, to any mode, made with the fault pin high again; a new edge always wins
    always_comb begin
        fault_nxt = fault_r;
        if (init_r && flt_sync) begin
            fault_nxt = 1'b0;
        end
        if (run && mode_r == OCC_MODE_PWM_FAULT && flt_fall) begin
            fault_nxt = 1'b1;
        end
    end

    // event counter: counts channel events, any write clears it
    // a clear and an event in one cycle leave a count of one
    always_comb begin
        evcnt_nxt = evcnt_r;
        if (wr_evcnt) begin
            evcnt_nxt = `OCC_EVCNT_RST;
        end
        if (evt_r) begin
            evcnt_nxt = wr_evcnt ? 16'h0001 : 16'(evcnt_r + 16'h0001);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_r <= 1'b0;
            oe_r <= 1'b0;
            evt_r <= 1'b0;
            seq_r <= OCC_SEQ_ARMED;
            fault_r <= 1'b0;
            evcnt_r <= `OCC_EVCNT_RST;
            eq_pri_prev_r <= 1'b0;
            eq_sec_prev_r <= 1'b0;
            flt_prev_r <= 1'b1;
        end else begin
            pin_r <= pin_nxt;
            oe_r <= (mode_r != OCC_MODE_OFF);
            evt_r <= evt_nxt;
            seq_r <= seq_nxt;
            fault_r <= fault_nxt;
            evcnt_r <= evcnt_nxt;
            // halted channel freezes its edge history too
            if (run) begin
                eq_pri_prev_r <= eq_pri;
                eq_sec_prev_r <= eq_sec;
                flt_prev_r <= flt_sync;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign compare_output_pin = pin_r;
    assign compare_output_enable = oe_r;
    assign compare_event = evt_r;

endmodule

//--- src/occ_match.sv
`timescale 1ns/1ps

// time base selection and equality against both compare registers
module occ_match (
    input wire logic tsel,
    input wire logic [15:0] second_timer_count,
    input wire logic second_timer_rollover,
    input wire logic [15:0] third_timer_count,
    input wire logic third_timer_rollover,
    input wire logic [15:0] cmp_pri,
    input wire logic [15:0] cmp_sec,
    output logic [15:0] count,
    output logic rollover,
    output logic eq_pri,
    output logic eq_sec
);
    assign count = tsel ? third_timer_count : second_timer_count;
    assign rollover = tsel ? third_timer_rollover
                           : second_timer_rollover;
    assign eq_pri = (count == cmp_pri);
    assign eq_sec = (count == cmp_sec);
endmodule

//--- src/occ_pkg.sv
package occ_pkg;

    typedef enum logic [2:0] {
        OCC_MODE_OFF = 3'b000,
        OCC_MODE_RISE_SHOT = 3'b001,
        OCC_MODE_FALL_SHOT = 3'b010,
        OCC_MODE_TOGGLE = 3'b011,
        OCC_MODE_DELAY_SHOT = 3'b100,
        OCC_MODE_PULSES = 3'b101,
        OCC_MODE_PWM = 3'b110,
        OCC_MODE_PWM_FAULT = 3'b111
    } occ_mode_t;

    typedef enum logic [1:0] {
        OCC_SEQ_ARMED = 2'b00,
        OCC_SEQ_ACTIVE = 2'b01,
        OCC_SEQ_DONE = 2'b10
    } occ_seq_t;

endpackage

//--- src/occ_regs.svh
`ifndef OCC_REGS_SVH
`define OCC_REGS_SVH

// register byte offsets on the apb bus
`define OCC_CTRL_OFS 8'h00
`define OCC_PRI_OFS 8'h04
`define OCC_SEC_OFS 8'h08
`define OCC_STAT_OFS 8'h0c
`define OCC_TIME_OFS 8'h10
`define OCC_EVCNT_OFS 8'h14

// compare_channel_control field positions
`define OCC_IDLE_BIT 13
`define OCC_FLT_BIT 4
`define OCC_TSEL_BIT 3
`define OCC_MODE_MSB 2
`define OCC_MODE_LSB 0

// status register field positions
`define OCC_ST_PIN_BIT 0
`define OCC_ST_OE_BIT 1
`define OCC_ST_RUN_BIT 2
`define OCC_ST_FIN_BIT 3
`define OCC_ST_SEQ_LSB 4
`define OCC_ST_SEQ_MSB 5

// reset values
`define OCC_CTRL_RST 16'h0000
`define OCC_CMP_RST 16'h0000
`define OCC_EVCNT_RST 16'h0000
`define OCC_ZERO16 16'h0000

`endif

//--- src/occ_sync.sv
`timescale 1ns/1ps

// two-flop synchroniser for a single pin level
module occ_sync #(
    parameter logic INIT = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r <= INIT;
            sync_out <= INIT;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

//--- test/occ_channel_properties.sv
`timescale 1ns/1ps

module occ_channel_properties
    import occ_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic compare_fault_input,
    input wire logic cpu_idle,
    input wire logic compare_output_pin,
    input wire logic compare_output_enable,
    input wire logic compare_event
);
    logic [15:0] ctrl_r;
    logic [2:0] mode;
    logic halted;
    logic ctrl_wr;
    assign ctrl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
    assign mode = ctrl_r[2:0];
    assign halted = ctrl_r[13] && cpu_idle;
    // shadow of the control word, only to qualify mode- and halt-dependent checks
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= 16'h0000;
        end else if (ctrl_wr) begin
            ctrl_r <= pwdata[15:0];
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_ctrl_wr;
        ctrl_wr;
    endsequence
    a_apb_ready: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_enable_mode: assert property (s_ctrl_wr |-> ##3
        compare_output_enable == (mode != 3'h0))
        else $error("enable does not follow mode");
    a_off_quiet: assert property (
        !compare_output_enable |-> !compare_event)
        else $error("event while disabled");
    a_rise_shot: assert property (mode == 3'h1 && compare_event
        |-> $rose(compare_output_pin)) else $error("event without rise");
    a_fall_event: assert property (
        mode inside {3'h2, 3'h4, 3'h5} && compare_event
        |-> $fell(compare_output_pin)) else $error("event without fall");
    a_toggle_edge: assert property (mode == 3'h3 && compare_event
        |-> $changed(compare_output_pin)) else $error("event without toggle");
    a_pwm_quiet: assert property (mode == 3'h6 |-> !compare_event)
        else $error("event in plain pwm");
    a_idle_freeze: assert property (halted
        |=> !compare_event && $stable(compare_output_pin))
        else $error("activity while halted");
    a_fault_event: assert property (mode == 3'h7 && !halted
        && $fell(compare_fault_input) |-> ##[1:4] compare_event)
        else $error("fault edge without event");
    a_fault_pin: assert property (
        mode == 3'h7 && compare_event |-> ##2 !compare_output_pin)
        else $error("pin high after fault");
endmodule

bind occ_channel occ_channel_properties occ_channel_properties_inst (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .compare_fault_input(compare_fault_input), .cpu_idle(cpu_idle),
    .compare_output_pin(compare_output_pin),
    .compare_output_enable(compare_output_enable),
    .compare_event(compare_event));

//--- test/occ_timer_model.sv
`timescale 1ns/1ps

// two up counters standing in for the second and third time bases
module occ_timer_model #(
    parameter logic [15:0] PER2 = 16'h0027,
    parameter logic [15:0] PER3 = 16'h0031
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    output logic [15:0] count2,
    output logic roll2,
    output logic [15:0] count3,
    output logic roll3
);
    // a stopped timer holds its count, so rollover pulses only while running
    assign roll2 = run && (count2 == PER2);
    assign roll3 = run && (count3 == PER3);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count2 <= 16'h0000;
            count3 <= 16'h0000;
        end else if (run) begin
            count2 <= roll2 ? 16'h0000 : count2 + 16'h0001;
            count3 <= roll3 ? 16'h0000 : count3 + 16'h0001;
        end
    end
endmodule

//--- test/tb.sv
`timescale 1ns/1ps
`include "occ_regs.svh"

module tb;
    import occ_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, pin, oe, evt, roll2, roll3, roll, mp, ms;
    logic [15:0] cnt2, cnt3, cnt;
    logic run = 1'b0, fault = 1'b1, cpu_idle = 1'b0, chk = 1'b0;
    int bad_count = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h0001_75d1;
    logic [2:0] m_mode = 3'h0;
    logic m_tsel = 1'b0, m_idle = 1'b0, m_pin = 1'b0, m_evt = 1'b0;
    logic m_done = 1'b0, m_eqp = 1'b0, m_eqs = 1'b0;
    logic [15:0] m_pri = 16'h0000, m_sec = 16'h0000;

    occ_channel occ_channel_inst (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .second_timer_count(cnt2),
        .second_timer_rollover(roll2), .third_timer_count(cnt3),
        .third_timer_rollover(roll3), .compare_fault_input(fault),
        .cpu_idle(cpu_idle), .compare_output_pin(pin),
        .compare_output_enable(oe), .compare_event(evt));
    occ_timer_model occ_timer_model_inst (.core_clk(core_clk), .rst(rst),
        .run(run), .count2(cnt2), .roll2(roll2), .count3(cnt3),
        .roll3(roll3));

    always #25 core_clk = ~core_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // reference channel: matches are the first cycle of equality
    assign cnt = m_tsel ? cnt3 : cnt2;
    assign roll = m_tsel ? roll3 : roll2;
    assign mp = (cnt == m_pri) && !m_eqp;
    assign ms = (cnt == m_sec) && !m_eqs;
    always @(posedge core_clk) begin
        m_evt <= 1'b0;
        if (m_mode != 3'h0 && !(m_idle && cpu_idle)) begin
            m_eqp <= cnt == m_pri;
            m_eqs <= cnt == m_sec;
            if (m_mode[2:1] == 2'h3) begin
                if (roll) begin
                    m_pin <= m_sec != 16'h0000;
                    m_pri <= m_sec;
                end else if (mp) begin
                    m_pin <= 1'b0;
                end
            end else if (m_mode == 3'h3 && mp) begin
                m_pin <= ~m_pin;
                m_evt <= 1'b1;
            end else if (m_mode[2] && ms && m_pin) begin
                m_pin <= 1'b0;
                m_evt <= 1'b1;
                m_done <= !m_mode[0];
            end else if (mp && !m_done && m_mode != 3'h3) begin
                m_pin <= m_mode != 3'h2;
                m_evt <= !m_mode[2];
                m_done <= !m_mode[2];
            end
        end
    end

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    always @(negedge core_clk) begin
        if (chk) begin
            check("pin", 32'(m_pin), 32'(pin));
            check("event", 32'(m_evt), 32'(evt));
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // only the watchdog ends a wait for pready
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_mode(input logic [2:0] md, input logic ts,
                            input logic ib, input int cycles);
        logic [31:0] q;
        logic e;
        logic [15:0] p;
        logic [15:0] s;
        p = 16'(xs() % 30);
        s = p + 16'h0001 + 16'(xs() % 8);
        run <= 1'b0;
        m_mode <= 3'h0;
        // park the channel so compare writes cannot act in the old mode
        apb(1'b1, `OCC_CTRL_OFS, 32'h0000_0000, q, e);
        apb(1'b1, `OCC_PRI_OFS, {16'h0000, p}, q, e);
        apb(1'b1, `OCC_SEC_OFS, {16'h0000, s}, q, e);
        apb(1'b1, `OCC_CTRL_OFS, {18'h0_0000, ib, 9'h000, ts, md}, q, e);
        m_mode <= md;
        m_tsel <= ts;
        m_idle <= ib;
        m_pri <= p;
        m_sec <= s;
        m_done <= 1'b0;
        // a stopped count already equal to a register is no new match
        m_eqp <= (ts ? cnt3 : cnt2) == p;
        m_eqs <= (ts ? cnt3 : cnt2) == s;
        if (md[2:1] == 2'h3) m_pin <= p != 16'h0000;
        else if (md != 3'h3) m_pin <= md == 3'h2;
        repeat (3) @(posedge core_clk);
        check("enable", 32'(md != 3'h0), 32'(oe));
        chk <= 1'b1;
        run <= 1'b1;
        repeat (cycles) begin
            cpu_idle <= (md[2:1] != 2'h3) && (xs() % 4 == 0);
            @(posedge core_clk);
        end
        cpu_idle <= 1'b0;
        chk <= 1'b0;
        $display("test mode %0d done", md);
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge core_clk);
        bad_count++;
        print_verdict();
    end

    initial begin
        logic [31:0] q;
        logic e;
        int n;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, `OCC_CTRL_OFS, 32'h0000_0000, q, e);
        check("ctrl reset", 32'h0000_0000, q);
        apb(1'b1, `OCC_CTRL_OFS, 32'hffff_fff0, q, e);
        apb(1'b0, `OCC_CTRL_OFS, 32'h0000_0000, q, e);
        check("ctrl reserved", 32'h0000_2000, q);
        apb(1'b0, 8'h18, 32'h0000_0000, q, e);
        check("unmapped err", 32'h0000_0001, 32'(e));
        check("unmapped data", 32'h0000_0000, q);
        run <= 1'b1;
        repeat (45) @(posedge core_clk);
        run <= 1'b0;
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, `OCC_CTRL_OFS, 32'(t) << 3, q, e);
            apb(1'b0, `OCC_TIME_OFS, 32'h0000_0000, q, e);
            check("time base", {16'h0000, t ? cnt3 : cnt2}, q);
        end
        $display("test setup done");
        for (int i = 0; i < 8; i++)
            run_mode(3'((i % 6) + 1), i[2], xs() % 2 == 0, 150);
        run_mode(3'h7, 1'b0, 1'b0, 60);
        run <= 1'b1;
        apb(1'b1, `OCC_EVCNT_OFS, 32'h0000_0000, q, e);
        fault <= 1'b0;
        n = 0;
        repeat (8) begin
            @(posedge core_clk);
            n = n + (evt === 1'b1);
        end
        check("fault events", 32'h0000_0001, 32'(n));
        check("fault pin", 32'h0000_0000, 32'(pin));
        run <= 1'b0;
        apb(1'b0, `OCC_CTRL_OFS, 32'h0000_0000, q, e);
        check("fault set", 32'h0000_0017, q);
        apb(1'b0, `OCC_EVCNT_OFS, 32'h0000_0000, q, e);
        check("event count", 32'h0000_0001, q);
        apb(1'b0, `OCC_STAT_OFS, 32'h0000_0000, q, e);
        check("status", 32'h0000_0006, q);
        fault <= 1'b1;
        repeat (4) @(posedge core_clk);
        apb(1'b1, `OCC_CTRL_OFS, 32'h0000_0007, q, e);
        apb(1'b0, `OCC_CTRL_OFS, 32'h0000_0000, q, e);
        check("fault clear", 32'h0000_0007, q);
        $display("test fault done");
        apb(1'b1, `OCC_CTRL_OFS, 32'h0000_0000, q, e);
        run <= 1'b1;
        repeat (60) @(posedge core_clk);
        check("off enable", 32'h0000_0000, 32'(oe));
        $display("test off done");
        print_verdict();
    end
endmodule
